/* File: rtl/scd_defines.vh */
// Purpose: constants for the system clock divider configuration controller
// Assumes: included by bare name from rtl files
// Notes: divider codes are 4-bit, divide ratio is two to the power of the code
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH

// ****************************************************************
// Controller registers on the AHB-Lite side (byte addresses)
// ****************************************************************
`define SCD_OFF_DIV_STAGE 8'h00
`define SCD_OFF_SRC_STAGE 8'h04
`define SCD_OFF_SRC_MHZ 8'h08
`define SCD_OFF_CMD 8'h0C
`define SCD_OFF_STATUS 8'h10
`define SCD_OFF_DIV_APPLIED 8'h14
`define SCD_OFF_SRC_APPLIED 8'h18

// ****************************************************************
// Command and status bit positions
// ****************************************************************
`define SCD_CMD_GO 0
`define SCD_CMD_CLR_DONE 1
`define SCD_ST_BUSY 0
`define SCD_ST_DONE 1
`define SCD_ST_REJECT 2
`define SCD_ST_FLAG_LSB 4
`define SCD_ST_FLAG_W 8

// ****************************************************************
// Divider word layout, one nibble per clock
// ****************************************************************
`define SCD_F_PERIPH_D 0
`define SCD_F_PERIPH_C 4
`define SCD_F_PERIPH_B 8
`define SCD_F_PERIPH_A 12
`define SCD_F_BUS_CLK 16
`define SCD_F_BUS_OUT_OFF 23
`define SCD_F_CORE 24
`define SCD_F_FLASH 28
`define SCD_CODE_MAX 4'h6

// ****************************************************************
// Source select word and device register codes
// ****************************************************************
`define SCD_SRC_FIELD_LSB 8
`define SCD_SRC_OSC 3'h2
`define SCD_SRC_PLL 3'h4
`define SCD_DEV_REG_WP 2'h0
`define SCD_DEV_REG_DIV 2'h1
`define SCD_DEV_REG_SRC 2'h2
`define SCD_WP_UNLOCK 32'h0000_A50B
`define SCD_WP_LOCK 32'h0000_A500
`define SCD_PERIPH_D_MAX_MHZ 32'h0000_0032

// ****************************************************************
// Reset values
// ****************************************************************
`define SCD_DIV_RESET 32'h2286_2666
`define SCD_SRC_RESET 16'h0200
`define SCD_MHZ_RESET 16'h000C

`endif

/* File: rtl/scd_field_chk.v */
// Purpose: judge one divider code against the selected clock source
// Assumes: code gives divide ratio two to the power of code
// Notes: purely combinational, one instance per divider field
`timescale 1ns/10ps
`include "scd_defines.vh"

module scd_field_chk #(
  parameter W = 4
) (
  // Field and source
  input wire [W-1:0] code,
  input wire pll_sel,
  input wire osc_sel,
  // Verdicts
  output wire pll_bad,
  output wire osc_bad,
  output wire code_bad
);

  // Division by one under the PLL, by one or two under the oscillator
  assign pll_bad = pll_sel && (code == {W{1'b0}}); // R7
  assign osc_bad = osc_sel && (code <= {{(W-1){1'b0}}, 1'b1}); // R10
  // Codes above the top ratio are not power-of-two dividers
  assign code_bad = (code > `SCD_CODE_MAX); // R2

endmodule

/* File: rtl/scd_ctrl.v */
// Purpose: host controller that checks and loads the device clock dividers
// Assumes: software stages values over AHB-Lite, then writes the go bit
// Notes: a rejected setting never reaches the device pins
//
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "scd_defines.vh"

// Notes on behaviour
// R1: clock B at integer multiple of clock D
// R2: clocks B and C in integer ratio
// R3: core and clock B in integer ratio
// R4: core and clock A in integer ratio
// R5: clock A at integer multiple of clock B
// R6: core and flash clock in integer ratio
// R7: no divide by one under PLL
// R8: core never slower than bus clock
// R9: bus clock output takes over shared pin
// R10: oscillator source forbids divide by one, two
// R11: small package: field equals highest core/B ratio
// R12: clock D at most 50 MHz
// R13: source word 0x0200 oscillator, 0x0400 PLL
// R14: device registers writable only when unprotected
module scd_ctrl #(
  parameter SMALL_PKG = 1,
  parameter AW = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [AW-1:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Device register write port
  output reg dev_wr_q,
  output reg [1:0] dev_reg_q,
  output reg [31:0] dev_wdata_q,
  // Shared pin ownership
  output reg port_pin_released_q
);

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_CHECK = 6'b000010;
  localparam [5:0] ST_UNLOCK = 6'b000100;
  localparam [5:0] ST_WR_DIV = 6'b001000;
  localparam [5:0] ST_WR_SRC = 6'b010000;
  localparam [5:0] ST_LOCK = 6'b100000;

  reg [5:0] state_q;
  reg [5:0] state_d;
  reg [31:0] div_stage_q;
  reg [15:0] src_stage_q;
  reg [15:0] src_mhz_q;
  reg [31:0] div_applied_q;
  reg [15:0] src_applied_q;
  reg done_q;
  reg reject_q;
  reg [7:0] flags_q;
  reg wr_pend_q;
  reg [AW-1:0] wr_addr_q;

  wire busy;
  wire addr_ok;
  wire [2:0] src_field;
  wire pll_sel;
  wire osc_sel;
  wire [3:0] c_d;
  wire [3:0] c_c;
  wire [3:0] c_b;
  wire [3:0] c_a;
  wire [3:0] c_bus;
  wire [3:0] c_core;
  wire [3:0] c_hi;
  wire [6:0] pll_bad;
  wire [6:0] osc_bad;
  wire [6:0] code_bad;
  wire [31:0] d_limit;
  wire [7:0] flags_d;
  wire go_wr;
  wire clr_wr;

  assign busy = (state_q != ST_IDLE);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************************************
  // Staged field extraction
  // ****************************************************************

  // Source field sits at bits 10:8 of the source word
  assign src_field = src_stage_q[`SCD_SRC_FIELD_LSB+2:`SCD_SRC_FIELD_LSB];
  assign osc_sel = (src_field == `SCD_SRC_OSC); // R13
  assign pll_sel = (src_field == `SCD_SRC_PLL); // R13
  assign c_d = div_stage_q[`SCD_F_PERIPH_D+3:`SCD_F_PERIPH_D];
  assign c_c = div_stage_q[`SCD_F_PERIPH_C+3:`SCD_F_PERIPH_C];
  assign c_b = div_stage_q[`SCD_F_PERIPH_B+3:`SCD_F_PERIPH_B];
  assign c_a = div_stage_q[`SCD_F_PERIPH_A+3:`SCD_F_PERIPH_A];
  assign c_bus = div_stage_q[`SCD_F_BUS_CLK+3:`SCD_F_BUS_CLK];
  assign c_core = div_stage_q[`SCD_F_CORE+3:`SCD_F_CORE];
  assign c_hi = (c_core > c_b) ? c_core : c_b;

  // ****************************************************************
  // Per-field source checks; nibble 5 carries the bus output bit
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_fld
      localparam integer NIB = (gi < 5) ? gi : gi + 1;
      scd_field_chk #(
        .W(4)
      ) u_chk (
        .code(div_stage_q[NIB*4+3:NIB*4]),
        .pll_sel(pll_sel),
        .osc_sel(osc_sel),
        .pll_bad(pll_bad[gi]),
        .osc_bad(osc_bad[gi]),
        .code_bad(code_bad[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Whole-word legality verdicts
  // ****************************************************************

  // Clock D ceiling scaled up by its own ratio, no divider needed
  assign d_limit = `SCD_PERIPH_D_MAX_MHZ << c_d;
  assign flags_d[0] = (c_b > c_d); // R1
  // Power-of-two ratios pair every clock as N:1 or 1:N when codes are legal
  assign flags_d[1] = |code_bad; // R2 R3 R4 R6
  assign flags_d[2] = |pll_bad; // R7
  assign flags_d[3] = (c_core > c_bus); // R8
  assign flags_d[4] = |osc_bad; // R10
  assign flags_d[5] = (SMALL_PKG != 0) && (c_c != c_hi); // R11
  assign flags_d[6] = ({16'h0000, src_mhz_q} > d_limit); // R12
  // Only the two documented source words may be sent
  assign flags_d[7] = (src_stage_q != 16'h0200) && (src_stage_q != 16'h0400) || (c_a > c_b); // R5 R13

  // ****************************************************************
  // AHB-Lite slave: address phase capture, zero wait states
  // ****************************************************************
  assign addr_ok = hsel && hready && htrans[1];
  assign go_wr = wr_pend_q && (wr_addr_q == `SCD_OFF_CMD) && hwdata[`SCD_CMD_GO];
  assign clr_wr = wr_pend_q && (wr_addr_q == `SCD_OFF_CMD) && hwdata[`SCD_CMD_CLR_DONE];

  // Write pending flag and address for the following data phase
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {AW{1'b0}};
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // Read data registered at the address phase, unmapped reads zero
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      case (haddr)
        `SCD_OFF_DIV_STAGE: hrdata <= div_stage_q;
        `SCD_OFF_SRC_STAGE: hrdata <= {16'h0000, src_stage_q};
        `SCD_OFF_SRC_MHZ: hrdata <= {16'h0000, src_mhz_q};
        `SCD_OFF_STATUS: hrdata <= {20'h0_0000, flags_q, 1'b0, reject_q, done_q, busy};
        `SCD_OFF_DIV_APPLIED: hrdata <= div_applied_q;
        `SCD_OFF_SRC_APPLIED: hrdata <= {16'h0000, src_applied_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Staging writes frozen while a load runs, so the pins see one setting
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_stage_q <= `SCD_DIV_RESET;
      src_stage_q <= `SCD_SRC_RESET;
      src_mhz_q <= `SCD_MHZ_RESET;
    end else if (wr_pend_q && !busy) begin
      if (wr_addr_q == `SCD_OFF_DIV_STAGE) begin
        div_stage_q <= hwdata;
      end
      if (wr_addr_q == `SCD_OFF_SRC_STAGE) begin
        src_stage_q <= hwdata[15:0];
      end
      if (wr_addr_q == `SCD_OFF_SRC_MHZ) begin
        src_mhz_q <= hwdata[15:0];
      end
    end
  end

  // ****************************************************************
  // Load sequencer
  // ****************************************************************

  // Next state; a go while busy is dropped
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (go_wr) begin
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        state_d = (|flags_d) ? ST_IDLE : ST_UNLOCK;
      end
      ST_UNLOCK: state_d = ST_WR_DIV;
      ST_WR_DIV: state_d = ST_WR_SRC;
      ST_WR_SRC: state_d = ST_LOCK;
      ST_LOCK: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Device port: one write per state, protection opened first and closed last
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dev_wr_q <= 1'b0;
      dev_reg_q <= `SCD_DEV_REG_WP;
      dev_wdata_q <= 32'h0000_0000;
    end else begin
      dev_wr_q <= 1'b0;
      case (state_q)
        ST_UNLOCK: begin
          dev_wr_q <= 1'b1; // R14
          dev_reg_q <= `SCD_DEV_REG_WP;
          dev_wdata_q <= `SCD_WP_UNLOCK;
        end
        ST_WR_DIV: begin
          dev_wr_q <= 1'b1;
          dev_reg_q <= `SCD_DEV_REG_DIV;
          dev_wdata_q <= div_stage_q;
        end
        ST_WR_SRC: begin
          dev_wr_q <= 1'b1; // R13
          dev_reg_q <= `SCD_DEV_REG_SRC;
          dev_wdata_q <= {16'h0000, src_stage_q};
        end
        ST_LOCK: begin
          dev_wr_q <= 1'b1; // R14
          dev_reg_q <= `SCD_DEV_REG_WP;
          dev_wdata_q <= `SCD_WP_LOCK;
        end
        default: begin
          dev_wr_q <= 1'b0;
        end
      endcase
    end
  end

  // Status and applied copies; a set of done wins over its clear
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      done_q <= 1'b0;
      reject_q <= 1'b0;
      flags_q <= 8'h00;
      div_applied_q <= 32'h0000_0000;
      src_applied_q <= 16'h0000;
      port_pin_released_q <= 1'b0;
    end else begin
      if (state_q == ST_LOCK) begin
        done_q <= 1'b1;
      end else if (clr_wr) begin
        done_q <= 1'b0;
      end
      if (state_q == ST_CHECK) begin
        flags_q <= flags_d;
        reject_q <= |flags_d;
      end
      if (state_q == ST_WR_SRC) begin
        div_applied_q <= div_stage_q;
        src_applied_q <= src_stage_q;
        // Bus clock out owns the shared pin; port logic must let go
        port_pin_released_q <= !div_stage_q[`SCD_F_BUS_OUT_OFF]; // R9
      end
    end
  end

endmodule

/* File: test/scd_ctrl_assertions.sv */
// Purpose: port checks for the clock divider controller
// Assumes: one clock, synchronous active low reset
// Notes: divider word judged when the source word goes out
`timescale 1ns/10ps
`include "scd_defines.vh"

module scd_ctrl_assertions #(
  parameter SMALL_PKG = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Device write port
  input wire dev_wr_q,
  input wire [1:0] dev_reg_q,
  input wire [31:0] dev_wdata_q,
  input wire port_pin_released_q
);
  reg [31:0] div_q;
  wire div_wr = dev_wr_q && dev_reg_q == `SCD_DEV_REG_DIV;
  wire src_wr = dev_wr_q && dev_reg_q == `SCD_DEV_REG_SRC;
  wire [3:0] big = (div_q[27:24] > div_q[11:8]) ? div_q[27:24] : div_q[11:8];
  // Smallest code over all seven divider fields
  function [3:0] min_code(input [31:0] w);
    integer k;
    begin
      min_code = w[31:28];
      for (k = 0; k < 28; k = k + 4) begin
        if (k != 20 && w[k +: 4] < min_code) begin
          min_code = w[k +: 4];
        end
      end
    end
  endfunction
  // Last divider word sent, judged one cycle later
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= 32'h0000_0000;
    end else if (div_wr) begin
      div_q <= dev_wdata_q;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_unlock_first: assert property (div_wr |-> $past(dev_wr_q) &&
    $past(dev_wdata_q) == `SCD_WP_UNLOCK) else $error("divider write not unlocked");
  chk_lock_after: assert property (src_wr |=> dev_wr_q &&
    dev_reg_q == `SCD_DEV_REG_WP && dev_wdata_q == `SCD_WP_LOCK) else $error("no relock");
  chk_src_word: assert property (src_wr |-> dev_wdata_q == 32'h0000_0200 ||
    dev_wdata_q == 32'h0000_0400) else $error("bad source word");
  chk_pll_div_one: assert property (src_wr && dev_wdata_q[10] |->
    min_code(div_q) != 4'h0) else $error("divide by one under pll");
  chk_osc_div_two: assert property (src_wr && dev_wdata_q[9] |->
    min_code(div_q) > 4'h1) else $error("divide by one or two under osc");
  chk_core_bus: assert property (src_wr |-> div_q[27:24] <= div_q[19:16])
    else $error("core slower than bus clock");
  chk_b_over_d: assert property (src_wr |-> div_q[11:8] <= div_q[3:0])
    else $error("clock b slower than d");
  chk_a_over_b: assert property (src_wr |-> div_q[15:12] <= div_q[11:8])
    else $error("clock a slower than b");
  chk_pkg_match: assert property (src_wr && SMALL_PKG != 0 |-> div_q[7:4] == big)
    else $error("clock c field not highest ratio");
  chk_pin_follow: assert property (src_wr |-> ##[1:2]
    port_pin_released_q == !div_q[`SCD_F_BUS_OUT_OFF]) else $error("pin state wrong");
endmodule

bind scd_ctrl scd_ctrl_assertions #(.SMALL_PKG(SMALL_PKG)) i_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .dev_wr_q(dev_wr_q), .dev_reg_q(dev_reg_q), .dev_wdata_q(dev_wdata_q),
  .port_pin_released_q(port_pin_released_q));

/* File: test/scd_dev_model.sv */
// Purpose: behavioural clock generation device behind the controller
// Assumes: one register write per strobe
// Notes: divider and source take writes only while unlocked
`timescale 1ns/10ps
`include "scd_defines.vh"

module scd_dev_model (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Register write port
  input wire dev_wr_q,
  input wire [1:0] dev_reg_q,
  input wire [31:0] dev_wdata_q,
  // Device state
  output reg [31:0] div_q,
  output reg [15:0] src_q,
  output reg wp_open_q,
  output wire src_pll,
  output wire pin_bus_clk
);
  assign src_pll = src_q == 16'h0400;
  assign pin_bus_clk = !div_q[`SCD_F_BUS_OUT_OFF];
  // Protected registers; a locked write is silently lost
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      div_q <= `SCD_DIV_RESET;
      src_q <= `SCD_SRC_RESET;
      wp_open_q <= 1'b0;
    end else if (dev_wr_q) begin
      if (dev_reg_q == `SCD_DEV_REG_WP) begin
        wp_open_q <= dev_wdata_q == `SCD_WP_UNLOCK;
      end
      if (wp_open_q && dev_reg_q == `SCD_DEV_REG_DIV) begin
        div_q <= dev_wdata_q;
      end
      if (wp_open_q && dev_reg_q == `SCD_DEV_REG_SRC) begin
        src_q <= dev_wdata_q[15:0];
      end
    end
  end
endmodule

/* File: test/system_clock_divider_config_bench.sv */
// Purpose: self-checking bench for the clock divider controller
// Assumes: zero wait AHB-Lite slave, device model on the write port
// Notes: rows hold staged settings and whether they must pass
`timescale 1ns/10ps
`include "scd_defines.vh"

module system_clock_divider_config_bench;
  reg clk_sys, rst_n, hsel, hwrite;
  reg [7:0] haddr;
  reg [1:0] htrans;
  reg [31:0] hwdata, rd, exp_div;
  reg [15:0] exp_src;
  reg [72:0] rows [0:10];
  wire hreadyout, hresp, dev_wr_q, port_pin_released_q, wp_open_q, src_pll, pin_bus_clk;
  wire [31:0] hrdata, dev_wdata_q, div_q;
  wire [15:0] src_q;
  wire [1:0] dev_reg_q;
  integer err_total, cmp_count, pulses, i;
  scd_ctrl #(.SMALL_PKG(1)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .dev_wr_q(dev_wr_q), .dev_reg_q(dev_reg_q), .dev_wdata_q(dev_wdata_q),
    .port_pin_released_q(port_pin_released_q));
  scd_dev_model i_dev (.clk_sys(clk_sys), .rst_n(rst_n), .dev_wr_q(dev_wr_q),
    .dev_reg_q(dev_reg_q), .dev_wdata_q(dev_wdata_q), .div_q(div_q), .src_q(src_q),
    .wp_open_q(wp_open_q), .src_pll(src_pll), .pin_bus_clk(pin_bus_clk));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Device strobes seen since the last go
  always @(posedge clk_sys) begin
    if (dev_wr_q === 1'b1) begin
      pulses <= pulses + 1;
    end
  end
  task close_out;
    begin
      $display("Checks %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task check(input string name, input [31:0] exp, input [31:0] got);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // Bounded wait for hready at a rising edge
  task wait_rdy;
    integer n;
    begin
      n = 0;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          err_total = err_total + 1;
          close_out;
        end
        @(posedge clk_sys);
      end
    end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy;
      rd = hrdata;
      check("okay", 0, hresp);
    end
  endtask
  // Stage, go, then status once the walk of up to five busy cycles is over
  task run(input [31:0] dv, input [15:0] sr, input [15:0] mhz);
    begin
      ahb(1'b1, `SCD_OFF_DIV_STAGE, dv);
      ahb(1'b1, `SCD_OFF_SRC_STAGE, {16'h0000, sr});
      ahb(1'b1, `SCD_OFF_SRC_MHZ, {16'h0000, mhz});
      pulses = 0;
      ahb(1'b1, `SCD_OFF_CMD, 32'h0000_0003);
      repeat (8) @(posedge clk_sys);
      ahb(1'b0, `SCD_OFF_STATUS, 32'h0000_0000);
    end
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = 0;
    {err_total, cmp_count, pulses} = 0;
    exp_div = `SCD_DIV_RESET;
    exp_src = `SCD_SRC_RESET;
    // Divider, source, MHz, expected flags, must pass
    rows[0] = {32'h2232_2334, 16'h0200, 16'h000C, 8'h00, 1'b1};
    rows[1] = {32'h1191_1112, 16'h0400, 16'h00C8, 8'h00, 1'b1};
    rows[2] = {32'h1191_1112, 16'h0400, 16'h00C9, 8'h40, 1'b0};
    rows[3] = {32'h0191_1112, 16'h0400, 16'h00C8, 8'h04, 1'b0};
    rows[4] = {32'h2132_2334, 16'h0200, 16'h000C, 8'h10, 1'b0};
    rows[5] = {32'h2432_2444, 16'h0200, 16'h000C, 8'h08, 1'b0};
    rows[6] = {32'h2232_2332, 16'h0200, 16'h000C, 8'h01, 1'b0};
    rows[7] = {32'h2232_4334, 16'h0200, 16'h000C, 8'h80, 1'b0};
    rows[8] = {32'h2232_2344, 16'h0200, 16'h000C, 8'h20, 1'b0};
    rows[9] = {32'h2232_2337, 16'h0200, 16'h000C, 8'h02, 1'b0};
    rows[10] = {32'h2232_2334, 16'h0300, 16'h000C, 8'h80, 1'b0};
    rst_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (i = 0; i < 11; i = i + 1) begin
      run(rows[i][72:41], rows[i][40:25], rows[i][24:9]);
      if (rows[i][0]) begin
        exp_div = rows[i][72:41];
        exp_src = rows[i][40:25];
      end
      check("rejected", !rows[i][0], rd[`SCD_ST_REJECT]);
      check("done", rows[i][0], rd[`SCD_ST_DONE]);
      check("flags", rows[i][8:1], rd[11:4]);
      check("strobes", rows[i][0] ? 4 : 0, pulses);
      check("device divider", exp_div, div_q);
      check("device source", exp_src, src_q);
      check("pll selected", exp_src == 16'h0400, src_pll);
      check("relocked", 0, wp_open_q);
      check("pin", !exp_div[`SCD_F_BUS_OUT_OFF], port_pin_released_q);
      ahb(1'b0, `SCD_OFF_DIV_APPLIED, 32'h0000_0000);
      check("applied", exp_div, rd);
      ahb(1'b0, `SCD_OFF_SRC_APPLIED, 32'h0000_0000);
      check("applied source", {16'h0000, exp_src}, rd);
    end
    // Go and staging while busy are ignored
    ahb(1'b1, `SCD_OFF_SRC_STAGE, 32'h0000_0200);
    pulses = 0;
    ahb(1'b1, `SCD_OFF_CMD, 32'h0000_0001);
    ahb(1'b1, `SCD_OFF_CMD, 32'h0000_0001);
    ahb(1'b1, `SCD_OFF_DIV_STAGE, 32'h0000_0000);
    repeat (10) @(posedge clk_sys);
    check("busy strobes", 4, pulses);
    // Done stays set until a clear on its own
    ahb(1'b0, `SCD_OFF_STATUS, 32'h0000_0000);
    check("done kept", 32'h0000_0002, rd);
    ahb(1'b1, `SCD_OFF_CMD, 32'h0000_0002);
    ahb(1'b0, `SCD_OFF_STATUS, 32'h0000_0000);
    check("done cleared", 0, rd);
    ahb(1'b0, `SCD_OFF_DIV_STAGE, 32'h0000_0000);
    check("stage kept", 32'h2232_2334, rd);
    ahb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped", 0, rd);
    // Reset while the sequencer is idle
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check("reset strobe", 0, {dev_wr_q, dev_reg_q, port_pin_released_q});
    check("reset data", 0, dev_wdata_q);
    ahb(1'b0, `SCD_OFF_DIV_STAGE, 32'h0000_0000);
    check("reset stage", `SCD_DIV_RESET, rd);
    ahb(1'b0, `SCD_OFF_SRC_STAGE, 32'h0000_0000);
    check("reset source", 32'h0000_0200, rd);
    ahb(1'b0, `SCD_OFF_SRC_MHZ, 32'h0000_0000);
    check("reset mhz", 32'h0000_000C, rd);
    close_out;
  end
endmodule
